// ===== bench/gpc_board_model.sv
`timescale 1ns/1ns
module gpc_board_model (
	// pad side
	input  wire [12:0] padOut,
	input  wire [12:0] padOe_n,
	// far-side levels
	input  wire [12:0] extLevel,
	output wire [12:0] padIn
);
	// the chip wins where it drives; elsewhere the board sets the level
	assign padIn = (padOut & ~padOe_n) | (extLevel & padOe_n);
endmodule // gpc_board_model

// ===== bench/gpc_pin_control_properties.sv
`timescale 1ns/1ns
module gpc_pin_control_props (
	// clock and reset
	input wire        clock,
	input wire        sys_rst,
	// writes and power controls
	input wire        outWrEn,
	input wire        outPort,
	input wire [7:0]  outWrMask,
	input wire [7:0]  outWrData,
	input wire        intClrEn,
	input wire        holdEn,
	input wire        wakeByReset,
	// state and pads
	input wire [12:0] outDataQ,
	input wire [12:0] pinStateQ,
	input wire [12:0] intStatusQ,
	input wire [1:0]  portIrqQ,
	input wire [12:0] padIn,
	input wire [12:0] padOut,
	input wire [12:0] padOe_n,
	input wire [38:0] padDriveMode
);
	default clocking @(posedge clock); endclocking
	rst_pads_off_a: assert property (sys_rst |=> &padOe_n &&
		padDriveMode == {13{3'h6}}) else $error("pads on after reset");
	rst_flags_a: assert property (sys_rst |=> intStatusQ == 13'h0 &&
		portIrqQ == 2'h0) else $error("flags kept by reset");
	wake_hiz_a: assert property (disable iff (sys_rst)
		wakeByReset |=> &padOe_n) else $error("pads driven on wake");
	state_lag_a: assert property (disable iff (sys_rst)
		!$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3) |->
		pinStateQ == $past(padIn, 3)) else $error("pin state lag");
	flag_cause_a: assert property (disable iff (sys_rst)
		(intStatusQ & ~$past(intStatusQ) & ~(pinStateQ ^ $past(pinStateQ)))
		== 13'h0) else $error("flag without edge");
	flag_clear_a: assert property (disable iff (sys_rst)
		(~intStatusQ & $past(intStatusQ)) != 13'h0 |->
		$past(intClrEn) || $past(sys_rst)) else $error("flag lost");
	irq_cause_a: assert property (disable iff (sys_rst)
		$rose(portIrqQ[0]) |-> (|intStatusQ[7:0]) ||
		(|($past(intStatusQ) & 13'h00FF))) else $error("request no flag");
	out_write_a: assert property (disable iff (sys_rst)
		outWrEn && !outPort |=> outDataQ[7:0] ==
		($past(outDataQ[7:0]) & ~$past(outWrMask) |
		$past(outWrData) & $past(outWrMask))) else $error("masked write");
	hold_frozen_a: assert property (disable iff (sys_rst)
		($rose(holdEn) && !wakeByReset) ##1 (holdEn && !wakeByReset)[*3]
		|-> $stable(padOut)) else $error("pads moved under hold");
endmodule // gpc_pin_control_props
bind gpc_pin_control gpc_pin_control_props u_props (.clock, .sys_rst,
	.outWrEn, .outPort, .outWrMask, .outWrData, .intClrEn, .holdEn,
	.wakeByReset, .outDataQ, .pinStateQ, .intStatusQ, .portIrqQ, .padIn,
	.padOut, .padOe_n, .padDriveMode);

// ===== bench/testbench.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
	logic        clock, sys_rst, cfgWrEn, cfgPort, outWrEn, outPort, e;
	logic        intClrEn, intClrPort, holdEn, wakeByReset;
	logic        deepSleep, sleepKeep;
	logic [2:0]  cfgPinInPort;
	logic [8:0]  cfgWrData, cfgRdData;
	logic [1:0]  cfgMuxSel, portIrqQ;
	logic [3:0]  cfgRdPin;
	logic [7:0]  outWrMask, outWrData, intClrMask;
	logic [12:0] outDataQ, pinStateQ, intStatusQ, periphA, periphB, periphC;
	logic [12:0] fixedEn, fixedOut, padIn, padOut, padOe_n, padVttl;
	logic [12:0] padSlow, padInEn, extLevel, mOut, mHeld;
	logic [38:0] padDriveMode;
	logic [31:0] seed, r;
	int          n_fail, checks, i;
	gpc_pin_control DUT (.clock, .sys_rst, .cfgWrEn, .cfgPort, .cfgPinInPort,
		.cfgWrData, .cfgMuxSel, .cfgRdPin, .cfgRdData, .outWrEn, .outPort,
		.outWrMask, .outWrData, .outDataQ, .pinStateQ, .intClrEn, .intClrPort,
		.intClrMask, .intStatusQ, .portIrqQ, .periphA, .periphB, .periphC,
		.fixedEn, .fixedOut, .holdEn, .deepSleep, .sleepKeep,
		.wakeByReset, .padIn, .padOut, .padOe_n, .padDriveMode, .padVttl,
		.padSlow, .padInEn);
	gpc_board_model board (.padOut, .padOe_n, .extLevel, .padIn);
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [8:0] cd(int k);
		return {2'h0, k[1], 1'b0, k[2], k[0], 3'(k % 8)};
	endfunction
	task automatic tick(int n);
		repeat (n) @(negedge clock);
	endtask
	// each task leaves a idle cycle so strobes never toggle twice at once
	task automatic cfg(int p, logic [8:0] d, logic [1:0] m);
		{cfgPort, cfgPinInPort} = 4'(p);
		{cfgWrData, cfgMuxSel} = {d, m};
		cfgWrEn = 1;
		tick(1);
		cfgWrEn = 0;
		tick(1);
	endtask
	task automatic outWr(logic pt, logic [7:0] mk, logic [7:0] dt);
		{outPort, outWrMask, outWrData} = {pt, mk, dt};
		for (int j = 0; j < 8; j++)
			if (mk[j] && pt * 8 + j < 13)
				mOut[pt * 8 + j] = dt[j];
		outWrEn = 1;
		tick(1);
		outWrEn = 0;
		tick(1);
	endtask
	task automatic clr(logic pt, logic [7:0] mk);
		{intClrPort, intClrMask} = {pt, mk};
		intClrEn = 1;
		tick(1);
		intClrEn = 0;
		tick(1);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		clock = 0;
		forever #2 clock = ~clock;
	end
	initial begin
		#200000;
		n_fail++;
		end_of_test();
	end
	initial begin
		{cfgWrEn, cfgPort, outWrEn, outPort, intClrEn, intClrPort} = '0;
		{holdEn, wakeByReset, cfgPinInPort, cfgWrData, cfgMuxSel} = '0;
		{deepSleep, sleepKeep} = 2'b00;
		{cfgRdPin, outWrMask, outWrData, intClrMask, fixedEn} = '0;
		{periphA, periphB, periphC, fixedOut, extLevel, mOut} = '0;
		seed = 32'hA2A8;
		sys_rst = 1;
		tick(4);
		sys_rst = 0;
		`CHK("padOe_n", 13'h1FFF, padOe_n)
		`CHK("padDriveMode", {13{3'h6}}, padDriveMode)
		$display("test reset done");
		for (i = 0; i < 13; i++)
			cfg(i, cd(i), 2'h0);
		// pin 13 does not exist, so this write must change nothing
		cfg(13, 9'h1FF, 2'h3);
		for (i = 0; i < 13; i++) begin
			cfgRdPin = 4'(i);
			tick(3);
			`CHK("cfgRdData", cd(i), cfgRdData)
			`CHK("padDriveMode", 3'(i % 8), padDriveMode[3*i+:3])
			`CHK("padVttl", i[0], padVttl[i])
			`CHK("padSlow", i[1], padSlow[i])
		end
		`CHK("padInEn", 2'h1, {padInEn[4], padInEn[0]})
		$display("test config done");
		for (i = 0; i < 13; i++)
			cfg(i, 9'h005, 2'h0);
		repeat (20) begin
			r = rnd();
			outWr(r[8], r[7:0], r[15:8]);
			tick(6);
			`CHK("outDataQ", mOut, outDataQ)
			`CHK("padOut", mOut, padOut)
			`CHK("pinStateQ", mOut, pinStateQ)
		end
		`CHK("padOe_n", 13'h0, padOe_n)
		$display("test data done");
		for (i = 1; i < 4; i++) begin
			cfg(0, 9'h005, 2'(i));
			periphA = 13'(rnd());
			periphB = ~periphA;
			periphC = 13'(rnd());
			fixedEn = 13'h0002;
			fixedOut = ~mOut;
			e = (i == 1) ? periphA[0] : (i == 2) ? periphB[0] : periphC[0];
			tick(4);
			`CHK("padOut0", e, padOut[0])
			`CHK("padOut1", ~mOut[1], padOut[1])
		end
		$display("test matrix done");
		fixedEn = 13'h0;
		cfg(0, 9'h005, 2'h0);
		cfg(2, 9'h080, 2'h0);
		cfg(9, 9'h000, 2'h0);
		tick(8);
		clr(1'b0, 8'hFF);
		clr(1'b1, 8'hFF);
		`CHK("intStatusQ", 13'h0, intStatusQ)
		extLevel = 13'h0204;
		tick(6);
		`CHK("intStatusQ", 13'h0004, intStatusQ)
		`CHK("portIrqQ", 2'h1, portIrqQ)
		`CHK("pinStateQ", 2'h3, {pinStateQ[9], pinStateQ[2]})
		clr(1'b0, 8'h04);
		tick(2);
		`CHK("intStatusQ", 13'h0, intStatusQ)
		`CHK("portIrqQ", 2'h0, portIrqQ)
		$display("test interrupt done");
		holdEn = 1;
		tick(4);
		mHeld = mOut;
		outWr(1'b0, 8'hFF, ~mOut[7:0]);
		tick(6);
		`CHK("outDataQ", mOut, outDataQ)
		`CHK("padOut", mHeld[7:3], padOut[7:3])
		wakeByReset = 1;
		tick(2);
		`CHK("padOe_n", 13'h1FFF, padOe_n)
		{wakeByReset, holdEn} = 2'b00;
		tick(2);
		// retention through deep sleep, then release by a new write
		{deepSleep, sleepKeep} = 2'b11;
		tick(4);
		mHeld = padOut;
		outWr(1'b0, 8'hFF, ~mOut[7:0]);
		tick(4);
		`CHK("padOut", mHeld, padOut)
		deepSleep = 0;
		outWr(1'b0, 8'hFF, ~mOut[7:0]);
		tick(4);
		`CHK("padOut", mOut, padOut)
		sleepKeep = 0;
		$display("test hold done");
		end_of_test();
	end
endmodule // testbench

// ===== hw/gpc_cfg_mem.v
`timescale 1ns/1ns
// per-pin configuration store, registered read port
module gpc_cfg_mem #(
	parameter WIDTH = 9,
	parameter DEPTH = 13,
	parameter AW    = 4
) (
	// clock and reset
	input  wire             clock,
	input  wire             sys_rst,
	// write port
	input  wire             wrEn,
	input  wire [AW-1:0]    wrAddr,
	input  wire [WIDTH-1:0] wrData,
	// read port
	input  wire [AW-1:0]    rdAddr,
	output reg  [WIDTH-1:0] rdData
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	always @(posedge clock) begin
		if (sys_rst) begin
			rdData <= {WIDTH{1'b0}};
		end else begin
			if (wrEn && (wrAddr < DEPTH))
				mem[wrAddr] <= wrData;
			if (rdAddr < DEPTH)
				rdData <= mem[rdAddr];
			else
				rdData <= {WIDTH{1'b0}};
		end
	end
endmodule // gpc_cfg_mem

// ===== hw/gpc_defines.vh
`ifndef GPC_DEFINES_VH
`define GPC_DEFINES_VH
// drive mode encodings (3 bits)
`define GPC_DM_INPUT      3'h0
`define GPC_DM_WUP_SDN    3'h1
`define GPC_DM_SUP_WDN    3'h2
`define GPC_DM_OD_LOW     3'h3
`define GPC_DM_OD_HIGH    3'h4
`define GPC_DM_STRONG     3'h5
`define GPC_DM_OFF        3'h6
`define GPC_DM_WEAK       3'h7
// per-pin configuration word field positions
`define GPC_CFG_W         9
`define GPC_CFG_DM_LO     0
`define GPC_CFG_DM_HI     2
`define GPC_CFG_VTTL      3
`define GPC_CFG_INDIS     4
`define GPC_CFG_OUTDIS    5
`define GPC_CFG_SLOW      6
`define GPC_CFG_IEDGE_LO  7
`define GPC_CFG_IEDGE_HI  8
// interrupt edge select
`define GPC_EDGE_NONE     2'h0
`define GPC_EDGE_RISE     2'h1
`define GPC_EDGE_FALL     2'h2
`define GPC_EDGE_BOTH     2'h3
// reset values and sizes
`define GPC_CFG_RST       9'h006
`define GPC_MUX_SW        2'h0
`define GPC_MUX_W         2
`define GPC_PINS          13
`define GPC_PORTS         2
`define GPC_PORT0_PINS    8
`endif

// ===== hw/gpc_pin_control.v
// Functional notes
// - each pin selects one of eight drive modes
// - each pin selects CMOS or LVTTL input threshold
// - input and output paths have separate disables
// - hold freezes pin outputs at their last state
// - each pin has a slew-rate select
// - during reset every pin sits in the disabled drive state
// - per-pin matrix picks software or peripheral source for each pin
// - fixed-function pins bypass the matrix
// - output-data register drives pins; pin-state register reads levels
// - software writes configuration, organised per port
// - pins interrupt only when their interrupt is enabled
// - each port combines its pin interrupts into one request
// - in deep sleep ports either keep state or stay operational
// - waking by reset puts all pins in high impedance
// - waking by interrupt keeps retained state until software rewrites
// - thirteen pins, all usable as general pins
// - hold and interrupt logic must not depend on the main clock; here both run on clock
`timescale 1ns/1ns
`include "gpc_defines.vh"
module gpc_pin_control #(
	parameter NPINS  = 13,
	parameter NPORT0 = 8
) (
	// clock and reset
	input  wire                  clock,
	input  wire                  sys_rst,
	// configuration write, one pin at a time
	input  wire                  cfgWrEn,
	input  wire                  cfgPort,
	input  wire [2:0]            cfgPinInPort,
	input  wire [8:0]            cfgWrData,
	input  wire [1:0]            cfgMuxSel,
	// configuration readback
	input  wire [3:0]            cfgRdPin,
	output reg  [8:0]            cfgRdData,
	// output data register, per port write with mask
	input  wire                  outWrEn,
	input  wire                  outPort,
	input  wire [7:0]            outWrMask,
	input  wire [7:0]            outWrData,
	output reg  [NPINS-1:0]      outDataQ,
	// pin state readback
	output reg  [NPINS-1:0]      pinStateQ,
	// interrupt status, write one to clear
	input  wire                  intClrEn,
	input  wire                  intClrPort,
	input  wire [7:0]            intClrMask,
	output reg  [NPINS-1:0]      intStatusQ,
	output reg  [1:0]            portIrqQ,
	// peripheral sources through the matrix
	input  wire [NPINS-1:0]      periphA,
	input  wire [NPINS-1:0]      periphB,
	input  wire [NPINS-1:0]      periphC,
	// fixed-function override, bypasses matrix
	input  wire [NPINS-1:0]      fixedEn,
	input  wire [NPINS-1:0]      fixedOut,
	// power state
	input  wire                  holdEn,
	input  wire                  deepSleep,
	input  wire                  sleepKeep,
	input  wire                  wakeByReset,
	// pads
	input  wire [NPINS-1:0]      padIn,
	output reg  [NPINS-1:0]      padOut,
	output reg  [NPINS-1:0]      padOe_n,
	output reg  [3*NPINS-1:0]    padDriveMode,
	output reg  [NPINS-1:0]      padVttl,
	output reg  [NPINS-1:0]      padSlow,
	output reg  [NPINS-1:0]      padInEn
);
	// flat pin index from port and pin-in-port
	function [3:0] pinIndex;
		input       port;
		input [2:0] sub;
		begin
			pinIndex = port ? (4'h8 + {1'b0, sub}) : {1'b0, sub};
		end
	endfunction

	// mask of pins belonging to a port
	function [NPINS-1:0] portMask;
		input       port;
		input [7:0] m;
		begin
			if (port)
				portMask = {m[NPINS-NPORT0-1:0], {NPORT0{1'b0}}};
			else
				portMask = {{(NPINS-NPORT0){1'b0}}, m[NPORT0-1:0]};
		end
	endfunction

	wire [3:0]         wrPin = pinIndex(cfgPort, cfgPinInPort);
	wire               wrOk  = cfgWrEn && (wrPin < NPINS);
	wire [NPINS-1:0]   pinSync;
	wire [8:0]         memRd;

	// shadow configuration, read back through a registered memory
	reg  [8:0]         cfg_q   [0:NPINS-1];
	reg  [1:0]         mux_q   [0:NPINS-1];
	reg  [NPINS-1:0]   pinSync_q;
	reg  [NPINS-1:0]   held_q;
	reg                holding_q;
	reg  [NPINS-1:0]   drvOut_d;
	reg  [NPINS-1:0]   drvOe_n_d;
	reg  [3*NPINS-1:0] dm_d;
	reg  [NPINS-1:0]   edge_d;
	reg  [NPINS-1:0]   oe_n_q;
	reg  [3*NPINS-1:0] dm_q;
	integer i;
	integer j;
	integer k;

	gpc_cfg_mem #(.WIDTH(9), .DEPTH(NPINS), .AW(4)) uMem (
		.clock  (clock),
		.sys_rst(sys_rst),
		.wrEn   (wrOk),
		.wrAddr (wrPin),
		.wrData (cfgWrData),
		.rdAddr (cfgRdPin),
		.rdData (memRd)
	);

	gpc_pin_sync #(.N(NPINS)) uSync (
		.clock  (clock),
		.sys_rst(sys_rst),
		.asyncIn(padIn),
		.syncOut(pinSync)
	);

	always @(posedge clock) begin
		if (sys_rst) begin
			for (i = 0; i < NPINS; i = i + 1) begin
				cfg_q[i] <= `GPC_CFG_RST;
				mux_q[i] <= `GPC_MUX_SW;
			end
		end else if (wrOk) begin
			cfg_q[wrPin] <= cfgWrData;
			mux_q[wrPin] <= cfgMuxSel;
		end
	end

	// source, drive and edge decode per pin
	always @* begin
		drvOut_d  = {NPINS{1'b0}};
		drvOe_n_d = {NPINS{1'b1}};
		dm_d      = {3*NPINS{1'b0}};
		edge_d    = {NPINS{1'b0}};
		for (j = 0; j < NPINS; j = j + 1) begin
			dm_d[3*j +: 3] = cfg_q[j][`GPC_CFG_DM_HI:`GPC_CFG_DM_LO];
			if (fixedEn[j])
				drvOut_d[j] = fixedOut[j];
			else if (mux_q[j] == 2'h1)
				drvOut_d[j] = periphA[j];
			else if (mux_q[j] == 2'h2)
				drvOut_d[j] = periphB[j];
			else if (mux_q[j] == 2'h3)
				drvOut_d[j] = periphC[j];
			else
				drvOut_d[j] = outDataQ[j];
			// open-drain modes release the pad on the passive level
			case (dm_d[3*j +: 3])
			`GPC_DM_INPUT, `GPC_DM_OFF:
				drvOe_n_d[j] = 1'b1;
			`GPC_DM_OD_LOW:
				drvOe_n_d[j] = drvOut_d[j];
			`GPC_DM_OD_HIGH:
				drvOe_n_d[j] = ~drvOut_d[j];
			default:
				drvOe_n_d[j] = 1'b0;
			endcase
			if (cfg_q[j][`GPC_CFG_OUTDIS])
				drvOe_n_d[j] = 1'b1;
			case (cfg_q[j][`GPC_CFG_IEDGE_HI:`GPC_CFG_IEDGE_LO])
			`GPC_EDGE_RISE:
				edge_d[j] = pinSync[j] & ~pinSync_q[j];
			`GPC_EDGE_FALL:
				edge_d[j] = ~pinSync[j] & pinSync_q[j];
			`GPC_EDGE_BOTH:
				edge_d[j] = pinSync[j] ^ pinSync_q[j];
			default:
				edge_d[j] = 1'b0;
			endcase
			if (cfg_q[j][`GPC_CFG_INDIS])
				edge_d[j] = 1'b0;
		end
	end

	// hold engages on request or on deep sleep with retention; once
	// engaged it stays until the request drops and software writes a configuration or output data, so a wake
	// by interrupt does not disturb the pads
	wire holdReq = holdEn | (deepSleep & sleepKeep);
	always @(posedge clock) begin
		if (sys_rst || wakeByReset) begin
			holding_q <= 1'b0;
			held_q    <= {NPINS{1'b0}};
			oe_n_q    <= {NPINS{1'b1}};
			dm_q      <= {NPINS{`GPC_DM_OFF}};
		end else if (holdReq && !holding_q) begin
			holding_q <= 1'b1;
			held_q    <= drvOut_d;
			oe_n_q    <= drvOe_n_d;
			dm_q      <= dm_d;
		end else if (holding_q && !holdReq && (wrOk || outWrEn)) begin
			holding_q <= 1'b0;
		end
	end

	// pad outputs are registered; the frozen copy wins while holding
	always @(posedge clock) begin
		if (sys_rst || wakeByReset) begin
			padOut       <= {NPINS{1'b0}};
			padOe_n      <= {NPINS{1'b1}};
			padDriveMode <= {NPINS{`GPC_DM_OFF}};
			padVttl      <= {NPINS{1'b0}};
			padSlow      <= {NPINS{1'b0}};
			padInEn      <= {NPINS{1'b0}};
		end else if (holding_q) begin
			padOut       <= held_q;
			padOe_n      <= oe_n_q;
			padDriveMode <= dm_q;
		end else begin
			padOut       <= drvOut_d;
			padOe_n      <= drvOe_n_d;
			padDriveMode <= dm_d;
			for (k = 0; k < NPINS; k = k + 1) begin
				padVttl[k] <= cfg_q[k][`GPC_CFG_VTTL];
				padSlow[k] <= cfg_q[k][`GPC_CFG_SLOW];
				padInEn[k] <= ~cfg_q[k][`GPC_CFG_INDIS];
			end
		end
	end

	// data, state and interrupt registers; a new edge beats a clear
	wire [NPINS-1:0] outM = portMask(outPort, outWrMask);
	wire [NPINS-1:0] outV = portMask(outPort, outWrData);
	wire [NPINS-1:0] clrM = intClrEn ?
		portMask(intClrPort, intClrMask) : {NPINS{1'b0}};
	wire [NPINS-1:0] intNext = (intStatusQ & ~clrM) | edge_d;
	always @(posedge clock) begin
		if (sys_rst) begin
			outDataQ   <= {NPINS{1'b0}};
			pinStateQ  <= {NPINS{1'b0}};
			pinSync_q  <= {NPINS{1'b0}};
			intStatusQ <= {NPINS{1'b0}};
			portIrqQ   <= 2'h0;
			cfgRdData  <= 9'h000;
		end else begin
			if (outWrEn)
				outDataQ <= (outDataQ & ~outM) | (outV & outM);
			pinSync_q  <= pinSync;
			pinStateQ  <= pinSync;
			intStatusQ <= intNext;
			portIrqQ[0] <= |intNext[NPORT0-1:0];
			portIrqQ[1] <= |intNext[NPINS-1:NPORT0];
			cfgRdData  <= memRd;
		end
	end
	// all thirteen pins are general; this model runs on one
	// clock, so the sleep clock must keep clock running in deep sleep
endmodule // gpc_pin_control

// ===== hw/gpc_pin_sync.v
`timescale 1ns/1ns
// two-stage synchroniser for pin input levels
module gpc_pin_sync #(
	parameter N = 13
) (
	input  wire         clock,
	input  wire         sys_rst,
	input  wire [N-1:0] asyncIn,
	output reg  [N-1:0] syncOut
);
	reg [N-1:0] meta_q;
	always @(posedge clock) begin
		if (sys_rst) begin
			meta_q  <= {N{1'b0}};
			syncOut <= {N{1'b0}};
		end else begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule // gpc_pin_sync
